// ---- core/ctmw_pkg.sv ----
// Constants and types of the transceiver mode and wake controller.
// Assumes a 25 MHz pclk and an APB master with 32-bit data.
// Operation
// - Receive-only keeps driver off, receiver running
// - Receive-only accepted only in chip Normal/Stop
// - Wake-capable mode monitors the bus
// - Fail-Safe entry forces wake-capable mode
// - Wake drives receive pin low until mode changes or chip Stop/Fail-Safe entry rearms
// - Wake pattern: dominant, recessive, dominant, timed
// - Mode field still reads wake-capable after wake
// - Mode toggle away and back rearms wake
// - Chip Stop or Fail-Safe entry rearms wake
// - Rearm ignores the bus wake flag
// - Wake in Normal/Stop: interrupt, flag, pin low
// - Wake in Stop leaves chip in Stop
// - Stop wake enables watchdog when configured
// - Sleep wake requests restart, pin low
// - Sleep wake raises no interrupt
// - Fail-Safe wake: restart, no interrupt; Restart wake: neither
// - Transmit dominant time-out disables driver, flags
// - Driver returns when transmit input recessive
// - Bus dominant time-out sets failure flag
// - Supply low checked in active modes during chip Normal/Stop, disables driver
// - Supply recovery resumes driving automatically
// - Off is reset default and ignores wake
package ctmw_pkg;
    // ********************************************************
    // Timing
    // ********************************************************
    localparam int unsigned CLK_PERIOD_NS   = 40;
    localparam int unsigned WAKE_FILTER_NS  = 1000;
    localparam int unsigned WAKE_TIMEOUT_NS = 1000000;
    localparam int unsigned TXD_TIMEOUT_NS  = 1000000;
    localparam int unsigned BUS_TIMEOUT_NS  = 1000000;
    // Least times round up to whole cycles
    localparam int unsigned WAKE_FILT_CYC =
        (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_TO_CYC =
        (WAKE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TXD_TO_CYC =
        (TXD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BUS_TO_CYC =
        (BUS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WAKE = 8'h04;
    localparam logic [7:0] REG_FAIL = 8'h08;
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_WDCFG_BIT = 2;
    localparam int WAKE_BUS_BIT   = 0;
    localparam int FAIL_CAN_BIT   = 0;
    localparam int FAIL_UV_BIT    = 1;
    localparam int FAIL_ARMED_BIT = 2;
    localparam int FAIL_TXTO_BIT  = 3;
    // ********************************************************
    // Encodings
    // ********************************************************
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_WAKE   = 2'h1;
    localparam logic [1:0] MODE_RXONLY = 2'h2;
    localparam logic [1:0] MODE_NORMAL = 2'h3;
    localparam logic [1:0] MODE_RST    = MODE_OFF;
    localparam logic [2:0] CHIP_NORMAL   = 3'h0;
    localparam logic [2:0] CHIP_STOP     = 3'h1;
    localparam logic [2:0] CHIP_SLEEP    = 3'h2;
    localparam logic [2:0] CHIP_RESTART  = 3'h3;
    localparam logic [2:0] CHIP_FAILSAFE = 3'h4;
    localparam logic [2:0] CHIP_INIT     = 3'h5;
    typedef enum logic [1:0] {WK_IDLE, WK_DOM1, WK_REC, WK_DOM2} ctmw_wk_t;
endpackage

// ---- core/ctmw_sync.sv ----
// Two-stage synchroniser for pin levels.
// Assumes inputs asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module ctmw_sync
#(
    parameter int W = 1
)
(
    input  wire logic         pclk,    // Clock
    input  wire logic         presetn, // Async reset, low
    input  wire logic [W-1:0] din,     // Raw pin levels
    output logic      [W-1:0] dout     // Synchronised levels
);
    typedef struct packed
    {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ctmw_sync_t;
    ctmw_sync_t st_ff;
    ctmw_sync_t nxt_st;
    // First stage feeds only the second
    always_comb
    begin
        nxt_st    = st_ff;
        nxt_st.s1 = din;
        nxt_st.s2 = st_ff.s1;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end
    assign dout = st_ff.s2;
endmodule
`default_nettype wire

// ---- core/ctmw_timer.sv ----
// Saturating phase counter: counts while run is high.
// Assumes run comes from the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module ctmw_timer
#(
    parameter int TW = 16
)
(
    input  wire logic          pclk,    // Clock
    input  wire logic          presetn, // Async reset, low
    input  wire logic          run,     // Count enable, else zero
    output logic      [TW-1:0] cnt      // Cycles counted
);
    typedef struct packed
    {
        logic [TW-1:0] cnt;
    } ctmw_tmr_t;
    ctmw_tmr_t st_ff;
    ctmw_tmr_t nxt_st;
    // Saturate so a stuck level never wraps to a short count
    always_comb
    begin
        nxt_st = st_ff;
        if (!run)
            nxt_st.cnt = '0;
        else if (st_ff.cnt != '1)
            nxt_st.cnt = st_ff.cnt + 1'b1;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end
    assign cnt = st_ff.cnt;
endmodule
`default_nettype wire

// ---- core/ctmw_ctrl.sv ----
// Transceiver mode, wake detection and fault controller.
// Assumes an APB master on pclk, chip mode from the chip state
// machine on pclk, and bus/transmit/supply levels from pins.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ctmw_ctrl
#(
    parameter int          TW            = 16,
    parameter int unsigned P_WAKE_FILT   = ctmw_pkg::WAKE_FILT_CYC,
    parameter int unsigned P_WAKE_TO     = ctmw_pkg::WAKE_TO_CYC,
    parameter int unsigned P_TXD_TO      = ctmw_pkg::TXD_TO_CYC,
    parameter int unsigned P_BUS_TO      = ctmw_pkg::BUS_TO_CYC
)
(
    input  wire logic        pclk,                      // Clock
    input  wire logic        presetn,                   // Async reset, low
    input  wire logic [7:0]  paddr,                     // APB address
    input  wire logic        psel,                      // APB select
    input  wire logic        penable,                   // APB enable
    input  wire logic        pwrite,                    // APB write
    input  wire logic [31:0] pwdata,                    // APB write data
    output logic      [31:0] prdata,                    // APB read data
    output logic             pready,                    // APB ready
    output logic             pslverr,                   // APB error
    input  wire logic [2:0]  chip_mode,                 // Chip-level mode
    input  wire logic        watchdog_enabled_in,       // Watchdog running
    input  wire logic        bus_transmit_in,           // Transmit pin, low dominant
    input  wire logic        bus_dominant_in,           // Receiver sees dominant
    input  wire logic        transceiver_supply_low_in, // Supply below threshold
    output logic             bus_receive_pin,           // Receive pin, low dominant
    output logic             bus_drive_dominant,        // Driver pulls dominant
    output logic             bus_driver_en,             // Driver stage enabled
    output logic             bus_bias_en,               // Half-supply bias on
    output logic             int_n,                     // Interrupt, low pulse
    output logic             restart_req,               // Chip restart request
    output logic             watchdog_enable_req        // Watchdog enable pulse
);
    import ctmw_pkg::*;

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed
    {
        logic [1:0]  mode;
        logic        wd_cfg;
        logic        bus_wake_flag;
        logic        can_fail;
        logic        supply_low_flag;
        logic        armed;
        logic        woke;
        logic        tx_to;
        logic        bus_to;
        logic        uv_act;
        ctmw_wk_t    wk;
        logic        prev_dom;
        logic [2:0]  prev_chip;
        logic        rxd;
        logic        drv;
        logic        tx_out;
        logic        bias;
        logic        irq;
        logic        restart;
        logic        wden;
        logic [31:0] rdata;
        logic        err;
    } ctmw_st_t;

    ctmw_st_t st_ff;
    ctmw_st_t nxt_st;

    logic [2:0]    pins_s;
    logic          txd_dom;
    logic          bus_dom;
    logic          supply_low;
    logic [TW-1:0] ph_cnt;
    logic [TW-1:0] tx_cnt;
    logic [TW-1:0] bus_cnt;
    logic          wake_run;
    logic          chg;
    logic          ph_ok;
    logic          ph_to;
    logic          wake_hit;
    logic          chip_ns;
    logic          active;
    logic          wr_en;
    logic          rd_setup;

    // ********************************************************
    // Pin synchronisers and phase counters
    // ********************************************************
    ctmw_sync #(.W(3)) u_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({transceiver_supply_low_in, bus_dominant_in, bus_transmit_in}),
        .dout    (pins_s)
    );

    // Transmit pin is low when dominant
    assign txd_dom    = ~pins_s[0];
    assign bus_dom    = pins_s[1];
    assign supply_low = pins_s[2];

    // Misc decodes
    assign chip_ns  = (chip_mode == CHIP_NORMAL) || (chip_mode == CHIP_STOP);
    assign active   = (st_ff.mode == MODE_NORMAL) || (st_ff.mode == MODE_RXONLY);
    assign wake_run = (st_ff.mode == MODE_WAKE) && st_ff.armed;
    assign chg      = bus_dom != st_ff.prev_dom;
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable;

    // phase counters
    // Counter restarts on every bus level change
    ctmw_timer #(.TW(TW)) u_phase
    (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (wake_run && !chg),
        .cnt     (ph_cnt)
    );

    ctmw_timer #(.TW(TW)) u_txd
    (
        .pclk    (pclk),
        .presetn (presetn),
        .run     ((st_ff.mode == MODE_NORMAL) && txd_dom),
        .cnt     (tx_cnt)
    );

    ctmw_timer #(.TW(TW)) u_bus
    (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (active && bus_dom),
        .cnt     (bus_cnt)
    );

    assign ph_ok = (ph_cnt >= TW'(P_WAKE_FILT)) && (ph_cnt < TW'(P_WAKE_TO));
    assign ph_to = ph_cnt >= TW'(P_WAKE_TO);

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb
    begin
        nxt_st           = st_ff;
        wake_hit         = 1'b0;
        nxt_st.irq       = 1'b0;
        nxt_st.restart   = 1'b0;
        nxt_st.wden      = 1'b0;
        nxt_st.prev_dom  = bus_dom;
        nxt_st.prev_chip = chip_mode;

        // pattern tracker
        // Runs only in armed wake-capable mode, so Off ignores the bus
        if (!wake_run)
            nxt_st.wk = WK_IDLE;
        else
        begin
            case (st_ff.wk)
                WK_IDLE:
                    if (chg && bus_dom)
                        nxt_st.wk = WK_DOM1;
                WK_DOM1:
                    if (ph_to)
                        nxt_st.wk = WK_IDLE;
                    else if (chg)
                        nxt_st.wk = ph_ok ? WK_REC : WK_IDLE;
                WK_REC:
                    // A short gap restarts the count at the new dominant
                    if (ph_to)
                        nxt_st.wk = WK_IDLE;
                    else if (chg)
                        nxt_st.wk = ph_ok ? WK_DOM2 : WK_DOM1;
                WK_DOM2:
                    if (ph_to)
                        nxt_st.wk = WK_IDLE;
                    else if (chg)
                    begin
                        nxt_st.wk = WK_IDLE;
                        wake_hit  = ph_ok;
                    end
                default:
                    nxt_st.wk = WK_IDLE;
            endcase
        end

        // Software clears first so a same-cycle hardware set wins
        if (wr_en && (paddr == REG_CTRL))
        begin
            if ((pwdata[CTRL_MODE_LSB +: 2] != MODE_RXONLY) || chip_ns)
                nxt_st.mode = pwdata[CTRL_MODE_LSB +: 2];
            nxt_st.wd_cfg = pwdata[CTRL_WDCFG_BIT];
        end
        if (wr_en && (paddr == REG_WAKE) && pwdata[WAKE_BUS_BIT])
            nxt_st.bus_wake_flag = 1'b0;
        if (wr_en && (paddr == REG_FAIL))
        begin
            if (pwdata[FAIL_CAN_BIT])
                nxt_st.can_fail = 1'b0;
            if (pwdata[FAIL_UV_BIT])
                nxt_st.supply_low_flag = 1'b0;
        end

        // rearm by leaving wake mode
        // The wake flag plays no part in rearming
        if (st_ff.mode != MODE_WAKE)
        begin
            nxt_st.armed = 1'b1;
            nxt_st.woke  = 1'b0;
        end
        // rearm on chip Stop or Fail-Safe entry
        if ((chip_mode != st_ff.prev_chip) &&
            ((chip_mode == CHIP_STOP) || (chip_mode == CHIP_FAILSAFE)))
        begin
            nxt_st.armed = 1'b1;
            nxt_st.woke  = 1'b0;
        end
        if ((chip_mode == CHIP_FAILSAFE) && (st_ff.prev_chip != CHIP_FAILSAFE))
            nxt_st.mode = MODE_WAKE;

        // wake keeps the mode field unchanged
        if (wake_hit)
        begin
            nxt_st.woke          = 1'b1;
            nxt_st.armed         = 1'b0;
            nxt_st.bus_wake_flag = 1'b1;
            case (chip_mode)
                CHIP_NORMAL:
                    nxt_st.irq = 1'b1;
                // stay in Stop, maybe start watchdog
                CHIP_STOP:
                begin
                    nxt_st.irq  = 1'b1;
                    nxt_st.wden = st_ff.wd_cfg && !watchdog_enabled_in;
                end
                CHIP_SLEEP,
                CHIP_FAILSAFE:
                    nxt_st.restart = 1'b1;
                default:
                    nxt_st.restart = 1'b0;
            endcase
        end

        // transmit dominant time-out
        // Clears itself once the transmit input goes recessive
        if ((st_ff.mode == MODE_NORMAL) && txd_dom && (tx_cnt >= TW'(P_TXD_TO)))
            nxt_st.tx_to = 1'b1;
        else if (!txd_dom || (st_ff.mode != MODE_NORMAL))
            nxt_st.tx_to = 1'b0;
        if (nxt_st.tx_to && !st_ff.tx_to)
            nxt_st.can_fail = 1'b1;

        // bus clamp detection
        // Needs the level still dominant, so a clamp must outlast the count
        nxt_st.bus_to = active && bus_dom && (bus_cnt >= TW'(P_BUS_TO));
        if (nxt_st.bus_to && !st_ff.bus_to)
            nxt_st.can_fail = 1'b1;

        // supply check only when it matters
        nxt_st.uv_act = active && chip_ns && supply_low;
        // Held set while low, so a clear during the fault does not stick
        if (nxt_st.uv_act)
            nxt_st.supply_low_flag = 1'b1;

        nxt_st.drv = (nxt_st.mode == MODE_NORMAL) && chip_ns &&
                     !nxt_st.tx_to && !nxt_st.uv_act;
        // driver follows the pin only once enabled
        nxt_st.tx_out = nxt_st.drv && txd_dom;
        nxt_st.bias   = (nxt_st.mode == MODE_NORMAL) || (nxt_st.mode == MODE_RXONLY);

        case (nxt_st.mode)
            MODE_NORMAL,
            MODE_RXONLY:
                nxt_st.rxd = ~bus_dom;
            MODE_WAKE:
                nxt_st.rxd = ~nxt_st.woke;
            default:
                nxt_st.rxd = 1'b1;
        endcase

        // Read data latched in setup so the access phase needs no wait
        if (rd_setup)
        begin
            nxt_st.err   = 1'b0;
            nxt_st.rdata = 32'h0;
            case (paddr)
                REG_CTRL:
                begin
                    nxt_st.rdata[CTRL_MODE_LSB +: 2] = st_ff.mode;
                    nxt_st.rdata[CTRL_WDCFG_BIT]     = st_ff.wd_cfg;
                end
                REG_WAKE:
                    nxt_st.rdata[WAKE_BUS_BIT] = st_ff.bus_wake_flag;
                REG_FAIL:
                begin
                    nxt_st.rdata[FAIL_CAN_BIT]   = st_ff.can_fail;
                    nxt_st.rdata[FAIL_UV_BIT]    = st_ff.supply_low_flag;
                    nxt_st.rdata[FAIL_ARMED_BIT] = st_ff.armed;
                    nxt_st.rdata[FAIL_TXTO_BIT]  = st_ff.tx_to;
                end
                default:
                    nxt_st.err = 1'b1;
            endcase
        end
    end

    // ********************************************************
    // Registers and outputs
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff      <= '0;
            st_ff.mode <= MODE_RST;
            st_ff.rxd  <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    assign prdata              = st_ff.rdata;
    assign pready              = 1'b1;
    assign pslverr             = st_ff.err && psel && penable;
    assign bus_receive_pin     = st_ff.rxd;
    assign bus_drive_dominant  = st_ff.tx_out;
    assign bus_driver_en       = st_ff.drv;
    assign bus_bias_en         = st_ff.bias;
    assign int_n               = ~st_ff.irq;
    assign restart_req         = st_ff.restart;
    assign watchdog_enable_req = st_ff.wden;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wake_stop;
        wake_hit && (chip_mode == CHIP_STOP) && (chip_mode == st_ff.prev_chip);
    endsequence
    sequence s_irq_flag;
        !int_n && st_ff.bus_wake_flag;
    endsequence

    AST_RXONLY_NO_DRIVE: assert property
        ((nxt_st.mode == MODE_RXONLY) |=> !bus_driver_en && !bus_drive_dominant)
        else $error("driver on in receive-only");
    AST_RXONLY_GATE: assert property
        (wr_en && (paddr == REG_CTRL) && !chip_ns &&
         (pwdata[1:0] == MODE_RXONLY) && (chip_mode != CHIP_FAILSAFE)
         |=> st_ff.mode == $past(st_ff.mode))
        else $error("receive-only taken outside Normal/Stop");
    AST_FAILSAFE_WAKE: assert property
        ((chip_mode == CHIP_FAILSAFE) && (st_ff.prev_chip != CHIP_FAILSAFE)
         |=> st_ff.mode == MODE_WAKE)
        else $error("Fail-Safe did not force wake mode");
    AST_WAKE_RXD_LOW: assert property
        (wake_hit && (chip_mode == st_ff.prev_chip) && !wr_en
         |-> ##2 !bus_receive_pin && (st_ff.mode == MODE_WAKE))
        else $error("receive pin not low after wake");
    AST_OFF_IGNORE: assert property
        ((st_ff.mode == MODE_OFF) |-> !wake_hit ##1 int_n && !restart_req)
        else $error("wake seen in Off mode");
    AST_STOP_INT: assert property
        (s_wake_stop |=> s_irq_flag ##1 int_n)
        else $error("Stop wake interrupt or flag wrong");
    AST_SLEEP_NO_INT: assert property
        (wake_hit && (chip_mode == CHIP_SLEEP) |=> restart_req && int_n)
        else $error("Sleep wake raised interrupt");
    AST_TX_TIMEOUT: assert property
        ($rose(st_ff.tx_to) |-> !bus_driver_en && st_ff.can_fail)
        else $error("transmit time-out not handled");
    AST_SUPPLY_LOW: assert property
        (nxt_st.uv_act |=> !bus_driver_en && st_ff.supply_low_flag)
        else $error("supply low left driver on");
endmodule
`default_nettype wire

// ---- verif/ctmw_bus_model.sv ----
// Far-side model: bus wire with other nodes, controller transmit pin.
// Assumes the bench clock; levels change just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module ctmw_bus_model
(
    input  wire logic pclk,    // Clock
    input  wire logic drv_dom, // Device pulls dominant
    input  wire logic drv_en,  // Device driver on
    output logic      bus_dom, // Wire, high dominant
    output var logic  tx_n     // Transmit pin, low dominant
);
    logic ext_dom; // Other nodes
    // Wired-OR: a dominant from anyone wins
    assign bus_dom = ext_dom | (drv_dom & drv_en);
    initial
    begin
        ext_dom = 1'b0;
        tx_n = 1'b1;
    end
    task automatic phase(input logic lvl, input int n);
        ext_dom <= lvl;
        repeat (n) @(posedge pclk);
    endtask
    task automatic wake_pattern(input int n);
        phase(1'b1, n);
        phase(1'b0, n);
        phase(1'b1, n);
        phase(1'b0, 8);
    endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Bench: APB tasks plus bus model drive the mode and wake controller.
// Assumes small timing parameters so the run stays short.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ctmw_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0]  chip_mode;
    logic        wd_on, sup_low, bus_dom, tx_n, pready, pslverr, slv, bias, clr_req;
    logic        rx, drv, drv_en, int_n, rst_req, wd_req, s_int, s_rst, s_wd;
    int          n_mismatch = 0;
    int          n_checks = 0;
    always #20 pclk = ~pclk;
    ctmw_bus_model bus_u (.pclk(pclk), .drv_dom(drv), .drv_en(drv_en),
        .bus_dom(bus_dom), .tx_n(tx_n));
    ctmw_ctrl #(.P_WAKE_FILT(4), .P_WAKE_TO(40), .P_TXD_TO(40), .P_BUS_TO(40)) dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chip_mode(chip_mode),
        .watchdog_enabled_in(wd_on), .bus_transmit_in(tx_n),
        .bus_dominant_in(bus_dom), .transceiver_supply_low_in(sup_low),
        .bus_receive_pin(rx), .bus_drive_dominant(drv), .bus_driver_en(drv_en),
        .bus_bias_en(bias), .int_n(int_n), .restart_req(rst_req),
        .watchdog_enable_req(wd_req));
    // Sticky catch of one-cycle pulses
    // Cleared in reset or on request, so only this process drives them
    always @(posedge pclk)
    begin
        if (!presetn || clr_req)
        begin
            s_int <= 1'b0;
            s_rst <= 1'b0;
            s_wd <= 1'b0;
        end
        else
        begin
            if (int_n === 1'b0) s_int <= 1'b1;
            if (rst_req === 1'b1) s_rst <= 1'b1;
            if (wd_req === 1'b1) s_wd <= 1'b1;
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Caller captures the value once it has settled
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        @(negedge pclk);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
        @(posedge pclk);
    endtask
    // One APB transfer; holds the request until pready is sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 50);
        if (i >= 50)
        begin
            n_mismatch++;
            summarize();
        end
        q = prdata;
        slv = pslverr;
        psel <= 0;
        penable <= 0;
        // One idle edge so pin outputs have settled for the caller
        @(posedge pclk);
    endtask
    task automatic clr();
        clr_req <= 1'b1;
        @(posedge pclk);
        clr_req <= 1'b0;
    endtask
    initial
    begin
        repeat (100000) @(posedge pclk);
        n_mismatch++;
        summarize();
    end
    initial
    begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        chip_mode <= CHIP_NORMAL;
        wd_on <= 1'b0;
        sup_low <= 1'b0;
        clr_req <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        xfer(0, REG_CTRL, 0);
        chk("mode_rst", MODE_OFF, q);
        bus_u.wake_pattern(10);
        xfer(0, REG_WAKE, 0);
        chk("off_wake", 0, q);
        xfer(0, 8'h0c, 0);
        chk("unmapped", 0, q);
        chk("unmapped_err", 1, slv);
        chip_mode <= CHIP_STOP;
        xfer(1, REG_CTRL, 32'h5);
        clr();
        bus_u.wake_pattern(10);
        chk("stop_int", 1, s_int);
        chk("stop_wd", 1, s_wd);
        chk("rx_low", 0, rx);
        xfer(0, REG_WAKE, 0);
        chk("wake_flag", 1, q);
        xfer(0, REG_CTRL, 0);
        chk("mode_wake", 32'h5, q);
        xfer(1, REG_CTRL, MODE_NORMAL);
        chk("rx_release", 1, rx);
        wd_on <= 1'b1;
        xfer(1, REG_CTRL, 32'h5);
        clr();
        bus_u.wake_pattern(10);
        chk("rearm_int", 1, s_int);
        chk("no_wd", 0, s_wd);
        xfer(1, REG_CTRL, MODE_OFF);
        xfer(1, REG_CTRL, MODE_WAKE);
        clr();
        bus_u.wake_pattern(2);
        chk("short_int", 0, s_int);
        xfer(1, REG_WAKE, 1);
        chip_mode <= CHIP_SLEEP;
        clr();
        bus_u.wake_pattern(10);
        chk("sleep_rst", 1, s_rst);
        chk("sleep_int", 0, s_int);
        chk("sleep_rx", 0, rx);
        xfer(0, REG_WAKE, 0);
        chk("sleep_flag", 1, q);
        chip_mode <= CHIP_STOP;
        repeat (2) @(posedge pclk);
        chk("stop_rx", 1, rx);
        xfer(0, REG_FAIL, 0);
        chk("armed", 1, q[FAIL_ARMED_BIT]);
        xfer(1, REG_CTRL, MODE_OFF);
        chip_mode <= CHIP_FAILSAFE;
        xfer(0, REG_CTRL, 0);
        chk("fs_mode", MODE_WAKE, q);
        clr();
        bus_u.wake_pattern(10);
        chk("fs_rst", 1, s_rst);
        chk("fs_int", 0, s_int);
        chip_mode <= CHIP_RESTART;
        xfer(1, REG_CTRL, MODE_RXONLY);
        xfer(0, REG_CTRL, 0);
        chk("rxo_refused", MODE_WAKE, q);
        chip_mode <= CHIP_NORMAL;
        xfer(1, REG_CTRL, MODE_OFF);
        xfer(1, REG_CTRL, MODE_WAKE);
        clr();
        bus_u.wake_pattern(10);
        chk("nrm_int", 1, s_int);
        xfer(1, REG_CTRL, MODE_RXONLY);
        xfer(0, REG_CTRL, 0);
        chk("rxo_mode", MODE_RXONLY, q);
        chk("rxo_drv", 0, drv_en);
        chk("rxo_bias", 1, bias);
        bus_u.phase(1, 4);
        chk("rxo_rx", 0, rx);
        bus_u.phase(1, 48);
        bus_u.phase(0, 4);
        xfer(0, REG_FAIL, 0);
        chk("clamp", 1, q[FAIL_CAN_BIT]);
        xfer(1, REG_FAIL, 1);
        xfer(1, REG_CTRL, MODE_NORMAL);
        chk("nrm_drv", 1, drv_en);
        bus_u.tx_n <= 0;
        repeat (50) @(posedge pclk);
        chk("txto_drv", 0, drv_en);
        xfer(0, REG_FAIL, 0);
        chk("txto_flag", 32'h9, q & 32'h9);
        bus_u.tx_n <= 1;
        repeat (4) @(posedge pclk);
        chk("tx_back", 1, drv_en);
        xfer(0, REG_CTRL, 0);
        chk("tx_cfg", MODE_NORMAL, q);
        sup_low <= 1;
        repeat (4) @(posedge pclk);
        chk("uv_drv", 0, drv_en);
        xfer(0, REG_FAIL, 0);
        chk("uv_flag", 1, q[FAIL_UV_BIT]);
        sup_low <= 0;
        repeat (4) @(posedge pclk);
        chk("uv_back", 1, drv_en);
        summarize();
    end
endmodule
`default_nettype wire
